// ===== core/serdes_pll_defs.svh
// Register offsets, field positions, reset values and port framing constants for the lane front end bank.
`ifndef SERDES_PLL_DEFS_SVH
`define SERDES_PLL_DEFS_SVH

`define ADDR_W 15
`define OFS_MASTER_OFF 15'h200
`define OFS_SYNC_BUF_PD 15'h203
`define OFS_RECOVERY_RESET 15'h206
`define OFS_RATE_MODE 15'h230
`define OFS_SETUP_BYTE 15'h232
`define OFS_EQ_POWER 15'h268
`define OFS_PLL_ENABLE 15'h280
`define OFS_PLL_STATE 15'h281
`define OFS_FILTER_A 15'h284
`define OFS_FILTER_B 15'h285
`define OFS_FILTER_C 15'h286
`define OFS_PUMP_A 15'h287

`define BIT_FIRST_SYNC_OFF 1
`define BIT_SECOND_SYNC_OFF 0
`define BIT_RECOVERY_RUN 0
`define BIT_HALF_RATE 5
`define BIT_OVERSAMPLE 1
`define BIT_PLL_RECAL 2
`define BIT_PLL_ON 0
`define BIT_BAND_HIGH 5
`define BIT_BAND_LOW 4
`define BIT_CAL_DONE 3
`define BIT_LOCKED 0

`define RST_MASTER_OFF 1'h1
`define RST_RECOVERY_RUN 1'h1
`define RST_HALF_RATE 1'h1
`define RST_RATE_MID 3'h2
`define RST_SETUP_BYTE 8'h00
`define RST_EQ_POWER 2'h1
`define RST_EQ_TRIM 6'h22
`define RST_FILTER_A 8'h77
`define RST_FILTER_B 8'h87
`define RST_FILTER_C 8'h08
`define RST_PUMP_A 8'h3f

// Serial port framing: 16 instruction bits, then one data byte.
`define SPI_LAST_INSTR_BIT 5'h0f
`define SPI_FIRST_DATA_BIT 5'h10
`define SPI_LAST_DATA_BIT 5'h17
`define SPI_FRAME_BITS 5'h18

`endif

// ===== core/serdes_pll_pkg.sv
// Types shared by the serial port and the lane front end register bank.
package serdes_pll_pkg;

    // One register access handed from the serial port to the bank.
    typedef struct packed {
        logic write;
        logic [14:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Status lines arriving from the analog serial PLL.
    typedef struct packed {
        logic band_high;
        logic band_low;
        logic cal_done;
        logic locked;
    } pll_state_t;

    // Calibration tracking.
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_WAIT_LOW = 2'b01,
        CAL_WAIT_DONE = 2'b10
    } cal_state_t;

endpackage

// ===== core/serdes_cfg_port.sv
// Serial configuration port slave: frames instruction and data bits into single register accesses.
`timescale 1ns/1ps
`include "serdes_pll_defs.svh"

module serdes_cfg_port (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_csb_n,
    input wire logic i_sdi,
    input wire logic [7:0] i_rdata,
    output logic o_req_valid,
    output serdes_pll_pkg::reg_req_t o_req,
    output logic o_sdo,
    output logic o_sdo_oe
);

    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_s3_reg;
    logic csb_s1_reg;
    logic csb_s2_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;
    logic [4:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    logic [14:0] addr_hold_reg;
    logic read_reg;
    logic [7:0] out_shift_reg;
    logic sclk_rise;
    logic sclk_fall;

    ////////////////////////////////////////////////////////////////////////////////
    // Pins are asynchronous to the system clock, so each passes two flip-flops first.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            csb_s1_reg <= 1'b1;
            csb_s2_reg <= 1'b1;
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= i_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            csb_s1_reg <= i_csb_n;
            csb_s2_reg <= csb_s1_reg;
            sdi_s1_reg <= i_sdi;
            sdi_s2_reg <= sdi_s1_reg;
        end
    end

    // Edges are judged on the second and third stages only.
    assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bits are taken on rising serial clock edges; extra bits after one byte are ignored.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || csb_s2_reg) begin
            bit_cnt_reg <= 5'h00;
            shift_reg <= 15'h0000;
            addr_hold_reg <= 15'h0000;
            read_reg <= 1'b0;
        end else if (sclk_rise && bit_cnt_reg != `SPI_FRAME_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg <= {shift_reg[13:0], sdi_s2_reg};
            if (bit_cnt_reg == `SPI_LAST_INSTR_BIT) begin
                addr_hold_reg <= {shift_reg[13:0], sdi_s2_reg};
                read_reg <= shift_reg[14];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A read is requested once the address is whole, a write once the data byte is whole.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_req_valid <= 1'b0;
            o_req <= '0;
        end else begin
            o_req_valid <= 1'b0;
            if (!csb_s2_reg && sclk_rise) begin
                if (bit_cnt_reg == `SPI_LAST_INSTR_BIT && shift_reg[14]) begin
                    o_req_valid <= 1'b1;
                    o_req <= '{write: 1'b0, addr: {shift_reg[13:0], sdi_s2_reg}, wdata: 8'h00};
                end else if (bit_cnt_reg == `SPI_LAST_DATA_BIT && !read_reg) begin
                    o_req_valid <= 1'b1;
                    o_req <= '{write: 1'b1, addr: addr_hold_reg, wdata: {shift_reg[6:0], sdi_s2_reg}};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data leave on falling edges so the master can take them on the next rising edge.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || csb_s2_reg) begin
            out_shift_reg <= 8'h00;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else if (sclk_fall && read_reg) begin
            if (bit_cnt_reg == `SPI_FIRST_DATA_BIT) begin
                out_shift_reg <= {i_rdata[6:0], 1'b0};
                o_sdo <= i_rdata[7];
                o_sdo_oe <= 1'b1;
            end else if (bit_cnt_reg > `SPI_FIRST_DATA_BIT && bit_cnt_reg <= `SPI_LAST_DATA_BIT) begin
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                o_sdo <= out_shift_reg[7];
            end else begin
                o_sdo_oe <= 1'b0; // The pin is released after the last data bit.
            end
        end
    end

endmodule

// ===== core/serdes_pll_ctrl_regs.sv
// Lane receiver front end and serial PLL control and status register bank.
//
// Notes on behaviour
// [RQ1] Sync buffer register bit 1 turns off first sync buffer, bit 0 second; reset on.
// [RQ2] Recovery run bit holds all lane recovery logic in reset while 0; resets to 1.
// [RQ3] Software sets half-rate enable for lane rates 5.75 to 12.4 Gbps; resets 1.
// [RQ4] Software sets oversample enable for lane rates 1.44 to 3.1 Gbps.
// [RQ5] Software writes the setup byte to all ones before use; resets to zero.
// [RQ6] Equalizer power field bits 7:6: 00 normal, 01 low power; resets low power.
// [RQ7] Software keeps the equalizer low six bits at their reset pattern.
// [RQ8] Each 0-to-1 write of PLL control bit 2 starts one new calibration.
// [RQ9] PLL control bit 0 turns the PLL on and calibrates it; resets off.
// [RQ10] Status bit 3 reads 1 once calibration finished successfully, else 0.
// [RQ11] Status bit 0 follows the PLL lock indication.
// [RQ12] Status bits 5 and 4 show band high and low edges; software then recalibrates.
// [RQ13] Software writes the three loop filter bytes with recommended values in order.
// [RQ14] Software writes the first charge pump byte with its recommended value.
// [RQ15] Master bit powers off all eight lane receivers and bias; resets set.
// [RQ16] Writes to read-only and reserved bits are ignored; status reads are live.
// [RQ17] During a triggered calibration the done and lock flags read 0.
`timescale 1ns/1ps
`include "serdes_pll_defs.svh"

module serdes_pll_ctrl_regs (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_csb_n,
    input wire logic i_sdi,
    input wire logic i_pll_locked,
    input wire logic i_pll_cal_done,
    input wire logic i_pll_band_high,
    input wire logic i_pll_band_low,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_receiver_analog_master_off,
    output logic o_first_sync_buffer_off,
    output logic o_second_sync_buffer_off,
    output logic o_lane_recovery_run_n_reset,
    output logic o_half_rate_enable,
    output logic [2:0] o_rate_mode_mid,
    output logic o_input_oversample_enable,
    output logic [7:0] o_setup_byte,
    output logic [1:0] o_equalizer_power_select,
    output logic [5:0] o_equalizer_trim,
    output logic o_pll_turn_on,
    output logic o_pll_cal_start,
    output logic [7:0] o_filter_a,
    output logic [7:0] o_filter_b,
    output logic [7:0] o_filter_c,
    output logic [7:0] o_pump_byte_a
);

    logic req_valid;
    serdes_pll_pkg::reg_req_t req;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wr;
    serdes_pll_pkg::pll_state_t pll_s1_reg;
    serdes_pll_pkg::pll_state_t pll_s2_reg;
    serdes_pll_pkg::cal_state_t cal_state_reg;
    logic pll_recal_reg;
    logic cal_trigger;
    logic cal_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial port front end.
    serdes_cfg_port serdes_cfg_port_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_sclk(i_sclk),
        .i_csb_n(i_csb_n),
        .i_sdi(i_sdi),
        .i_rdata(rdata_reg),
        .o_req_valid(req_valid),
        .o_req(req),
        .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe)
    );

    assign wr = req_valid & req.write;

    ////////////////////////////////////////////////////////////////////////////////
    // PLL status comes from the analog macro on its own timing, so it is synchronised.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pll_s1_reg <= '0;
            pll_s2_reg <= '0;
        end else begin
            pll_s1_reg <= '{band_high: i_pll_band_high, band_low: i_pll_band_low,
                            cal_done: i_pll_cal_done, locked: i_pll_locked};
            pll_s2_reg <= pll_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-down, recovery reset and rate mode controls; reserved bits are never stored.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_receiver_analog_master_off <= `RST_MASTER_OFF; // [RQ15]
            o_first_sync_buffer_off <= 1'b0; // [RQ1]
            o_second_sync_buffer_off <= 1'b0; // [RQ1]
            o_lane_recovery_run_n_reset <= `RST_RECOVERY_RUN; // [RQ2]
            o_half_rate_enable <= `RST_HALF_RATE;
            o_rate_mode_mid <= `RST_RATE_MID;
            o_input_oversample_enable <= 1'b0;
        end else if (wr) begin
            if (req.addr == `OFS_MASTER_OFF) begin
                o_receiver_analog_master_off <= req.wdata[0]; // [RQ15]
            end else if (req.addr == `OFS_SYNC_BUF_PD) begin
                o_first_sync_buffer_off <= req.wdata[`BIT_FIRST_SYNC_OFF]; // [RQ1]
                o_second_sync_buffer_off <= req.wdata[`BIT_SECOND_SYNC_OFF]; // [RQ1]
            end else if (req.addr == `OFS_RECOVERY_RESET) begin
                o_lane_recovery_run_n_reset <= req.wdata[`BIT_RECOVERY_RUN]; // [RQ2]
            end else if (req.addr == `OFS_RATE_MODE) begin
                o_half_rate_enable <= req.wdata[`BIT_HALF_RATE];
                o_rate_mode_mid <= req.wdata[4:2];
                o_input_oversample_enable <= req.wdata[`BIT_OVERSAMPLE]; // [RQ16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tuning bytes: stored whole, the values are the software's responsibility.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_setup_byte <= `RST_SETUP_BYTE;
            o_equalizer_power_select <= `RST_EQ_POWER; // [RQ6]
            o_equalizer_trim <= `RST_EQ_TRIM;
            o_filter_a <= `RST_FILTER_A;
            o_filter_b <= `RST_FILTER_B;
            o_filter_c <= `RST_FILTER_C;
            o_pump_byte_a <= `RST_PUMP_A;
        end else if (wr) begin
            if (req.addr == `OFS_SETUP_BYTE) begin
                o_setup_byte <= req.wdata;
            end else if (req.addr == `OFS_EQ_POWER) begin
                o_equalizer_power_select <= req.wdata[7:6]; // [RQ6]
                o_equalizer_trim <= req.wdata[5:0];
            end else if (req.addr == `OFS_FILTER_A) begin
                o_filter_a <= req.wdata;
            end else if (req.addr == `OFS_FILTER_B) begin
                o_filter_b <= req.wdata;
            end else if (req.addr == `OFS_FILTER_C) begin
                o_filter_c <= req.wdata;
            end else if (req.addr == `OFS_PUMP_A) begin
                o_pump_byte_a <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PLL enable and recalibrate bits; a calibration starts on either bit going 0 to 1.
    assign cal_trigger = wr && req.addr == `OFS_PLL_ENABLE &&
                         ((req.wdata[`BIT_PLL_RECAL] && !pll_recal_reg) || // [RQ8]
                          (req.wdata[`BIT_PLL_ON] && !o_pll_turn_on)); // [RQ9]

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_pll_turn_on <= 1'b0; // [RQ9]
            pll_recal_reg <= 1'b0;
            o_pll_cal_start <= 1'b0;
        end else begin
            o_pll_cal_start <= cal_trigger; // [RQ8]
            if (wr && req.addr == `OFS_PLL_ENABLE) begin
                o_pll_turn_on <= req.wdata[`BIT_PLL_ON]; // [RQ9]
                pll_recal_reg <= req.wdata[`BIT_PLL_RECAL];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A new calibration counts as finished only after the done line has dropped and risen again,
    // so a stale done from the previous run cannot end it early.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cal_state_reg <= serdes_pll_pkg::CAL_IDLE;
        end else if (cal_trigger) begin
            cal_state_reg <= serdes_pll_pkg::CAL_WAIT_LOW; // [RQ17]
        end else begin
            case (cal_state_reg)
                serdes_pll_pkg::CAL_WAIT_LOW: begin
                    if (!pll_s2_reg.cal_done) begin
                        cal_state_reg <= serdes_pll_pkg::CAL_WAIT_DONE;
                    end
                end
                serdes_pll_pkg::CAL_WAIT_DONE: begin
                    if (pll_s2_reg.cal_done) begin
                        cal_state_reg <= serdes_pll_pkg::CAL_IDLE;
                    end
                end
                default: begin
                    cal_state_reg <= serdes_pll_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    assign cal_busy = cal_state_reg != serdes_pll_pkg::CAL_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data; unmapped addresses and reserved bits read as zero.
    always_comb begin
        rdata_next = 8'h00;
        if (req.addr == `OFS_MASTER_OFF) begin
            rdata_next[0] = o_receiver_analog_master_off;
        end else if (req.addr == `OFS_SYNC_BUF_PD) begin
            rdata_next[`BIT_FIRST_SYNC_OFF] = o_first_sync_buffer_off;
            rdata_next[`BIT_SECOND_SYNC_OFF] = o_second_sync_buffer_off;
        end else if (req.addr == `OFS_RECOVERY_RESET) begin
            rdata_next[`BIT_RECOVERY_RUN] = o_lane_recovery_run_n_reset;
        end else if (req.addr == `OFS_RATE_MODE) begin
            rdata_next = {2'h0, o_half_rate_enable, o_rate_mode_mid, o_input_oversample_enable, 1'b0};
        end else if (req.addr == `OFS_SETUP_BYTE) begin
            rdata_next = o_setup_byte;
        end else if (req.addr == `OFS_EQ_POWER) begin
            rdata_next = {o_equalizer_power_select, o_equalizer_trim};
        end else if (req.addr == `OFS_PLL_ENABLE) begin
            rdata_next[`BIT_PLL_RECAL] = pll_recal_reg;
            rdata_next[`BIT_PLL_ON] = o_pll_turn_on;
        end else if (req.addr == `OFS_PLL_STATE) begin
            rdata_next[`BIT_BAND_HIGH] = pll_s2_reg.band_high; // [RQ12]
            rdata_next[`BIT_BAND_LOW] = pll_s2_reg.band_low; // [RQ12]
            rdata_next[`BIT_CAL_DONE] = pll_s2_reg.cal_done & ~cal_busy; // [RQ10] [RQ17]
            rdata_next[`BIT_LOCKED] = pll_s2_reg.locked & ~cal_busy; // [RQ11] [RQ17]
        end else if (req.addr == `OFS_FILTER_A) begin
            rdata_next = o_filter_a;
        end else if (req.addr == `OFS_FILTER_B) begin
            rdata_next = o_filter_b;
        end else if (req.addr == `OFS_FILTER_C) begin
            rdata_next = o_filter_c;
        end else if (req.addr == `OFS_PUMP_A) begin
            rdata_next = o_pump_byte_a;
        end
    end

    // Status is captured at request time, so a read shows the live PLL state. [RQ16]
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rdata_reg <= 8'h00;
        end else if (req_valid && !req.write) begin
            rdata_reg <= rdata_next;
        end
    end

endmodule

// ===== tb/serdes_pll_ctrl_regs_asserts.sv
// Concurrent checks on the ports of the lane front end register bank.
`timescale 1ns/1ps

module serdes_pll_ctrl_regs_asserts (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_csb_n,
    input wire logic o_receiver_analog_master_off,
    input wire logic o_first_sync_buffer_off,
    input wire logic o_second_sync_buffer_off,
    input wire logic o_lane_recovery_run_n_reset,
    input wire logic o_half_rate_enable,
    input wire logic [1:0] o_equalizer_power_select,
    input wire logic [5:0] o_equalizer_trim,
    input wire logic [7:0] o_setup_byte,
    input wire logic [7:0] o_filter_a,
    input wire logic [7:0] o_pump_byte_a,
    input wire logic o_pll_turn_on,
    input wire logic o_pll_cal_start
);
    ////////////////////////////////////////////////////////////////
    // One clock domain, so clock and reset are given once for all checks.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // Settings that only a finished serial frame may change.
    logic [37:0] cfg_bus;
    assign cfg_bus = {o_receiver_analog_master_off, o_first_sync_buffer_off, o_second_sync_buffer_off,
        o_lane_recovery_run_n_reset, o_half_rate_enable, o_equalizer_power_select, o_equalizer_trim,
        o_setup_byte, o_filter_a, o_pump_byte_a, o_pll_turn_on};

    ////////////////////////////////////////////////////////////////
    a_cal_pulse_single: assert property (o_pll_cal_start |=> !o_pll_cal_start)
        else $error("calibration start lasted more than one cycle");
    a_cal_on_enable: assert property ($rose(o_pll_turn_on) |-> ##[0:1] o_pll_cal_start)
        else $error("turning the pll on started no calibration");
    a_idle_cfg_stable: assert property (i_csb_n [*8] |=> $stable(cfg_bus))
        else $error("a setting changed with no frame in progress");
    a_reset_master_off: assert property ($rose(i_rst_n) |-> o_receiver_analog_master_off)
        else $error("receiver master power bit not set after reset");
    a_reset_run_bit: assert property (!$past(i_rst_n) |-> o_lane_recovery_run_n_reset && o_half_rate_enable)
        else $error("recovery run or half rate bit wrong after reset");
    a_reset_eq_power: assert property ($rose(i_rst_n) |->
        o_equalizer_power_select == 2'h1 && o_equalizer_trim == 6'h22)
        else $error("equalizer register wrong after reset");
    a_reset_pll_off: assert property (!$past(i_rst_n) |-> !o_pll_turn_on && !o_pll_cal_start)
        else $error("pll enabled or calibrating after reset");
    a_reset_sync_on: assert property ($rose(i_rst_n) |->
        !o_first_sync_buffer_off && !o_second_sync_buffer_off)
        else $error("sync buffer powered down after reset");
endmodule

// ===== tb/tb_serdes_pll_ctrl_regs.sv
// Self-checking bench for the lane front end register bank, driven through its serial port.
`timescale 1ns/1ps
`include "serdes_pll_defs.svh"

module tb_serdes_pll_ctrl_regs;
    logic i_clk_sys, i_rst_n, i_sclk, i_csb_n, i_sdi;
    logic i_pll_locked, i_pll_cal_done, i_pll_band_high, i_pll_band_low;
    logic o_sdo, o_sdo_oe, o_master_off, o_first_off, o_second_off, o_run, o_half, o_over, o_on, o_cal;
    logic [2:0] o_mid;
    logic [1:0] o_eq;
    logic [5:0] o_trim;
    logic [7:0] o_setup, o_fa, o_fb, o_fc, o_pump, v;
    int bad_count, samples_checked, cycle_count, pulse_count;
    logic [14:0] addr_tab [12] = '{`OFS_MASTER_OFF, `OFS_SYNC_BUF_PD, `OFS_RECOVERY_RESET, `OFS_RATE_MODE,
        `OFS_SETUP_BYTE, `OFS_EQ_POWER, `OFS_PLL_ENABLE, `OFS_PLL_STATE, `OFS_FILTER_A, `OFS_FILTER_B,
        `OFS_FILTER_C, `OFS_PUMP_A};
    logic [7:0] rst_tab [12] = '{8'h01, 8'h00, 8'h01, 8'h28, 8'h00, 8'h62, 8'h00, 8'h00, 8'h77, 8'h87, 8'h08, 8'h3f};
    logic [7:0] wr_tab [12] = '{8'hfe, 8'hff, 8'hfe, 8'hff, 8'hff, 8'h22, 8'h00, 8'hff, 8'h62, 8'hc9, 8'h0e, 8'h12};
    logic [7:0] rb_tab [12] = '{8'h00, 8'h03, 8'h00, 8'h3e, 8'hff, 8'h22, 8'h00, 8'h00, 8'h62, 8'hc9, 8'h0e, 8'h12};

    serdes_pll_ctrl_regs serdes_pll_ctrl_regs_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
        .i_csb_n(i_csb_n), .i_sdi(i_sdi), .i_pll_locked(i_pll_locked), .i_pll_cal_done(i_pll_cal_done),
        .i_pll_band_high(i_pll_band_high), .i_pll_band_low(i_pll_band_low), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
        .o_receiver_analog_master_off(o_master_off), .o_first_sync_buffer_off(o_first_off),
        .o_second_sync_buffer_off(o_second_off), .o_lane_recovery_run_n_reset(o_run), .o_half_rate_enable(o_half),
        .o_rate_mode_mid(o_mid), .o_input_oversample_enable(o_over), .o_setup_byte(o_setup),
        .o_equalizer_power_select(o_eq), .o_equalizer_trim(o_trim), .o_pll_turn_on(o_on), .o_pll_cal_start(o_cal),
        .o_filter_a(o_fa), .o_filter_b(o_fb), .o_filter_c(o_fc), .o_pump_byte_a(o_pump));

    ////////////////////////////////////////////////////////////////
    // Clock at 20 MHz.
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    // Cuts a hang short and counts calibration start pulses.
    always @(posedge i_clk_sys) begin
        cycle_count++;
        if (o_cal === 1'b1) pulse_count++;
        if (cycle_count == 30000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One whole frame; six cycle sclk phases leave margin over the synchroniser delay.
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] rv);
        logic [23:0] bits;
        bits = {rd, a, d};
        rv = 8'h00;
        i_csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            i_sdi = bits[i];
            tick(6);
            i_sclk = 1'b1;
            if (i < 8) rv[i] = o_sdo;
            if (rd && i == 0) check("sdo drive", o_sdo_oe, 8'h01);
            tick(6);
            i_sclk = 1'b0;
        end
        tick(6);
        i_csb_n = 1'b1;
        i_sdi = 1'b0;
        tick(8);
    endtask

    task automatic rd_check(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] rv;
        frame(1'b1, a, 8'h00, rv);
        check($sformatf("reg %h", a), rv, exp);
        check("sdo release", o_sdo_oe, 8'h00);
    endtask

    // Writes the pll control register and counts the calibration starts it causes.
    task automatic pll_write(input logic [7:0] d, input logic [7:0] pulses);
        pulse_count = 0;
        frame(1'b0, `OFS_PLL_ENABLE, d, v);
        check("cal pulses", pulse_count[7:0], pulses);
    endtask

    task automatic set_pll(input logic lock, input logic cal, input logic hi, input logic lo);
        {i_pll_locked, i_pll_cal_done, i_pll_band_high, i_pll_band_low} = {lock, cal, hi, lo};
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {i_rst_n, i_sclk, i_sdi, i_pll_locked, i_pll_cal_done, i_pll_band_high, i_pll_band_low} = 7'h00;
        i_csb_n = 1'b1;
        tick(3);
        i_rst_n = 1'b1;
        tick(3);
        for (int i = 0; i < 12; i++) rd_check(addr_tab[i], rst_tab[i]);
        rd_check(15'h2ff, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 12; i++) frame(1'b0, addr_tab[i], wr_tab[i], v);
        for (int i = 0; i < 12; i++) rd_check(addr_tab[i], rb_tab[i]);
        check("buffers off", {o_first_off, o_second_off, o_run, o_master_off}, 8'h0c);
        check("rate mode", {o_half, o_over, o_eq, 2'h0, o_setup == 8'hff}, 8'h61);
        check("rate mid", o_mid, 8'h07);
        check("eq trim", o_trim, 8'h22);
        check("pump", o_pump, 8'h12);
        check("filters", o_fa ^ o_fb ^ o_fc, 8'h62 ^ 8'hc9 ^ 8'h0e);
        frame(1'b0, `OFS_SYNC_BUF_PD, 8'h01, v);
        check("second sync only", {o_first_off, o_second_off}, 8'h01);
        frame(1'b0, 15'h2fe, 8'hff, v);
        rd_check(15'h2fe, 8'h00);
        $display("test write readback done");
        set_pll(1'b1, 1'b1, 1'b1, 1'b0);
        rd_check(`OFS_PLL_STATE, 8'h29);
        set_pll(1'b1, 1'b1, 1'b0, 1'b1);
        rd_check(`OFS_PLL_STATE, 8'h19);
        pll_write(8'h01, 8'h01);
        check("pll on", o_on, 8'h01);
        rd_check(`OFS_PLL_STATE, 8'h10);
        set_pll(1'b1, 1'b0, 1'b0, 1'b1);
        set_pll(1'b1, 1'b1, 1'b0, 1'b1);
        rd_check(`OFS_PLL_STATE, 8'h19);
        pll_write(8'h01, 8'h00);
        pll_write(8'h05, 8'h01);
        pll_write(8'h05, 8'h00);
        pll_write(8'h01, 8'h00);
        pll_write(8'hff, 8'h01);
        rd_check(`OFS_PLL_ENABLE, 8'h05);
        set_pll(1'b0, 1'b0, 1'b0, 1'b0);
        set_pll(1'b0, 1'b1, 1'b0, 1'b0);
        rd_check(`OFS_PLL_STATE, 8'h08);
        $display("test pll calibration done");
        i_rst_n = 1'b0;
        tick(3);
        i_rst_n = 1'b1;
        tick(3);
        check("after reset", {o_on, o_master_off, o_eq}, 8'h05);
        rd_check(`OFS_FILTER_A, 8'h77);
        $display("test second reset done");
        print_verdict();
    end
endmodule

bind serdes_pll_ctrl_regs serdes_pll_ctrl_regs_asserts serdes_pll_ctrl_regs_asserts_inst (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_csb_n(i_csb_n), .o_receiver_analog_master_off(o_receiver_analog_master_off),
    .o_first_sync_buffer_off(o_first_sync_buffer_off), .o_second_sync_buffer_off(o_second_sync_buffer_off),
    .o_lane_recovery_run_n_reset(o_lane_recovery_run_n_reset), .o_half_rate_enable(o_half_rate_enable),
    .o_equalizer_power_select(o_equalizer_power_select), .o_equalizer_trim(o_equalizer_trim),
    .o_setup_byte(o_setup_byte), .o_filter_a(o_filter_a), .o_pump_byte_a(o_pump_byte_a),
    .o_pll_turn_on(o_pll_turn_on), .o_pll_cal_start(o_pll_cal_start));
